//--- logic/rcit_timer.sv
// Purpose: Repeat cycle interval timer core with APB register access.
// Assumes: Panel buttons and sensor level arrive already debounced, asynchronous.
// Notes: Power return is signalled by a pulse on power_return.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "rcit_cfg.svh"
module rcit_timer #(
  parameter int SEC_CYCLES = `RCIT_SEC_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire rcit_pkg::rcit_apb_req_t apb_req,
  output rcit_pkg::rcit_apb_rsp_t apb_rsp,
  // Sensor and front panel
  input wire logic sensor_in,
  input wire logic start_btn,
  input wire logic stop_btn,
  input wire logic reset_btn,
  input wire logic total_btn,
  input wire logic power_return,
  // Status
  output rcit_pkg::rcit_state_t timer_state,
  output logic [18:0] shown_sec
);
  import rcit_pkg::*;

  rcit_regs_t r;
  rcit_regs_t next_r;
  logic start_lvl, prev_lvl, start_evt, stop_evt, rst_evt, tot_evt, pwr_evt, tick;
  logic [18:0] tv;
  logic wr, setup;

  // Multiple of sixty check, shared by format and edit guards
  function automatic logic min_ok(input logic [18:0] v);
    return (v % 19'd60) == 19'd0;
  endfunction

  // Seconds into display fields of the chosen format
  function automatic logic [31:0] fmt_time(input logic [18:0] s, input rcit_fmt_t f);
    logic [18:0] h, m, mt, sc;
    h = s / 19'd3600;
    mt = s / 19'd60;
    m = mt % 19'd60;
    sc = s % 19'd60;
    unique case (f)
      RCIT_HMS: fmt_time = {8'h00, h[7:0], m[7:0], sc[7:0]};
      RCIT_HM: fmt_time = {16'h0000, h[7:0], m[7:0]};
      RCIT_MS: fmt_time = {8'h00, mt[15:0], sc[7:0]};
      RCIT_S: fmt_time = {13'h0000, s};
    endcase
  endfunction

  // Clamp to the format's largest value
  function automatic logic [18:0] clamp(input logic [31:0] v, input rcit_fmt_t f);
    logic [18:0] mx;
    mx = (f == RCIT_HM) ? `RCIT_MAX_HM_SEC : `RCIT_MAX_SEC;
    return (v > {13'h0000, mx}) ? mx : v[18:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `RCIT_OFF_DREM;
  endfunction

  // Sensor polarity: control 2 and current loop each invert
  assign start_lvl = r.s2[0] ^ r.cfg.ctl2 ^ r.cfg.prox;
  assign prev_lvl = r.s3[0] ^ r.cfg.ctl2 ^ r.cfg.prox;
  assign start_evt = (start_lvl & ~prev_lvl) | (r.s2[1] & ~r.s3[1]);
  assign stop_evt = (~start_lvl & prev_lvl) | (r.s2[2] & ~r.s3[2]);
  // Panel resets only outside configuration and only when enabled
  assign rst_evt = r.s2[3] & ~r.s3[3] & r.cfg.lrst_en & ~r.cfg_mode;
  assign tot_evt = r.s2[4] & ~r.s3[4] & r.cfg.trst_en & ~r.cfg_mode;
  assign pwr_evt = r.s2[5] & ~r.s3[5];
  // One second base from the divided clock
  assign tick = (r.st == RCIT_RUN || r.st == RCIT_DELAY) && r.pre == SEC_CYCLES - 1;
  // Up shows elapsed, down shows remaining
  assign tv = r.cfg.dir_up ? r.el : r.setp - r.el;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign setup = apb_req.psel & ~apb_req.penable;

  // Zero wait state slave; read data prepared in setup phase
  assign apb_rsp = '{pready: 1'b1,
                     pslverr: apb_req.psel & apb_req.penable & ~mapped(apb_req.paddr),
                     prdata: r.prdata};
  assign timer_state = r.st;
  assign shown_sec = tv;

  // Next state of the whole block
  always_comb begin
    logic edit_ok, cyc_more;
    logic [18:0] v;
    logic [31:0] rd;
    edit_ok = 1'b0;
    cyc_more = 1'b0;
    v = 19'h00000;
    rd = 32'h00000000;
    next_r = r;
    next_r.s1 = {power_return, total_btn, reset_btn, stop_btn, start_btn, sensor_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.pre = tick ? 32'h00000000 : r.pre + 32'h00000001;
    if (r.st != RCIT_RUN && r.st != RCIT_DELAY) begin
      next_r.pre = 32'h00000000;
    end
    // Timing sequence
    unique case (r.st)
      RCIT_IDLE: begin
        if (start_evt && r.setp != 19'h00000) begin
          next_r.st = RCIT_RUN;
        end
      end
      RCIT_RUN: begin
        if (stop_evt) begin
          next_r.st = RCIT_PAUSE;
        end else if (tick) begin
          if (r.el + 19'h00001 >= r.setp) begin
            // Continuous repeat wraps the shown cycle number
            next_r.done_cyc = (r.done_cyc == `RCIT_MAX_CYC) ? 7'h00 : r.done_cyc + 7'h01;
            cyc_more = r.rcnt == 7'h00 || r.done_cyc + 7'h01 < r.rcnt;
            if (r.cfg.cyc_en && cyc_more) begin
              next_r.el = 19'h00000;
              next_r.dl = 19'h00000;
              next_r.st = (r.dly == 19'h00000) ? RCIT_RUN : RCIT_DELAY;
            end else begin
              next_r.el = r.setp;
              next_r.st = RCIT_DONE;
            end
          end else begin
            next_r.el = r.el + 19'h00001;
          end
        end
      end
      RCIT_PAUSE: begin
        if (start_evt) begin
          next_r.st = RCIT_RUN;
        end
      end
      RCIT_DELAY: begin
        if (tick) begin
          if (r.dl + 19'h00001 >= r.dly) begin
            next_r.dl = 19'h00000;
            next_r.st = RCIT_RUN;
          end else begin
            next_r.dl = r.dl + 19'h00001;
          end
        end
      end
      RCIT_DONE: begin
        next_r.st = RCIT_DONE;
      end
      default: next_r.st = RCIT_IDLE;
    endcase
    // Run total in tenths of an hour, counted only while timing
    if (tick && r.st == RCIT_RUN) begin
      if (r.run_sec == `RCIT_SEC_PER_TENTH - 9'h001) begin
        next_r.run_sec = 9'h000;
        next_r.tenths = r.tenths + 16'h0001;
      end else begin
        next_r.run_sec = r.run_sec + 9'h001;
      end
    end
    // Register writes
    if (wr) begin
      edit_ok = r.cfg_mode || (r.cfg.adj_en && (r.code_act == 16'h0000 || r.unlocked));
      unique case (apb_req.paddr)
        `RCIT_OFF_CTRL: begin
          if (r.cfg_mode) begin
            // Repeat enable is its own bit, count and delay stay put
            next_r.cfg = apb_req.pwdata[10:0];
            if (next_r.cfg.fmt == RCIT_HM && !(min_ok(r.setp) && min_ok(r.dly))) begin
              next_r.cfg.fmt = r.cfg.fmt;
            end
          end
        end
        `RCIT_OFF_SETP: begin
          v = clamp(apb_req.pwdata, RCIT_S);
          if (edit_ok && (r.cfg.fmt != RCIT_HM || min_ok(v))) begin
            next_r.setp = v;
          end
        end
        `RCIT_OFF_RCNT: begin
          if (r.cfg_mode && apb_req.pwdata <= 32'(`RCIT_MAX_CYC)) begin
            next_r.rcnt = apb_req.pwdata[6:0];
          end
        end
        `RCIT_OFF_DLY: begin
          v = clamp(apb_req.pwdata, r.cfg.fmt);
          if (edit_ok && (r.cfg.fmt != RCIT_HM || min_ok(v))) begin
            next_r.dly = v;
          end
        end
        `RCIT_OFF_CODE: begin
          if (r.cfg_mode) begin
            next_r.code_pend = apb_req.pwdata[15:0];
          end
        end
        `RCIT_OFF_CFGM: begin
          next_r.cfg_mode = apb_req.pwdata[0];
          if (r.cfg_mode && !apb_req.pwdata[0]) begin
            next_r.code_act = r.code_pend;
          end
        end
        `RCIT_OFF_UNLK: begin
          next_r.unlocked = r.code_act == 16'h0000 || apb_req.pwdata[15:0] == r.code_act;
        end
        default: next_r.cfg_mode = r.cfg_mode;
      endcase
    end
    // Resets from panel or command word
    if (rst_evt || (wr && apb_req.paddr == `RCIT_OFF_CMD && apb_req.pwdata[0])) begin
      next_r.st = RCIT_IDLE;
      next_r.el = 19'h00000;
      next_r.dl = 19'h00000;
      next_r.done_cyc = 7'h00;
    end
    if (tot_evt || (wr && apb_req.paddr == `RCIT_OFF_CMD && apb_req.pwdata[1])) begin
      next_r.run_sec = 9'h000;
      next_r.tenths = 16'h0000;
    end
    // Power return policy wins over everything else
    if (pwr_evt && r.st != RCIT_IDLE) begin
      next_r.pre = 32'h00000000;
      // Time and cycle count freeze at the moment of loss, even on a tick
      next_r.el = r.el;
      next_r.dl = r.dl;
      next_r.done_cyc = r.done_cyc;
      unique case (r.cfg.policy)
        RCIT_P_IDLE: next_r.st = RCIT_DONE;
        RCIT_P_PAUSE: next_r.st = start_lvl ? RCIT_RUN : RCIT_PAUSE;
        RCIT_P_CONT: next_r.st = r.st;
        default: next_r.st = r.st;
      endcase
    end
    // Read data latched in setup phase, held through access
    unique case (apb_req.paddr)
      `RCIT_OFF_CTRL: rd = {21'h000000, r.cfg};
      `RCIT_OFF_SETP: rd = fmt_time(r.setp, r.cfg.fmt);
      `RCIT_OFF_RCNT: rd = {25'h0000000, r.rcnt};
      `RCIT_OFF_DLY: rd = fmt_time(r.dly, r.cfg.fmt);
      `RCIT_OFF_CODE: rd = {16'h0000, r.code_pend};
      `RCIT_OFF_CFGM: rd = {31'h00000000, r.cfg_mode};
      `RCIT_OFF_UNLK: rd = {31'h00000000, r.unlocked};
      `RCIT_OFF_STAT: rd = {21'h000000, r.done_cyc, start_lvl, r.st};
      `RCIT_OFF_TIME: rd = fmt_time(tv, r.cfg.fmt);
      `RCIT_OFF_TOT: rd = {16'h0000, r.tenths};
      `RCIT_OFF_DREM: rd = fmt_time(r.dly - r.dl, r.cfg.fmt);
      default: rd = 32'h00000000;
    endcase
    if (setup) begin
      next_r.prdata = rd;
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r <= '{st: RCIT_IDLE, cfg: `RCIT_CTRL_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Checks
  a_zero_setpoint: assert property (@(posedge ref_clk) disable iff (reset)
    r.st == RCIT_IDLE && r.setp == 19'h00000 && !pwr_evt |=> r.st == RCIT_IDLE)
    else $error("timer left idle with zero setpoint");
  a_elapsed_limit: assert property (@(posedge ref_clk) disable iff (reset)
    r.el <= r.setp && r.setp <= `RCIT_MAX_SEC)
    else $error("elapsed time beyond limit");
  a_hm_guard: assert property (@(posedge ref_clk) disable iff (reset)
    r.cfg.fmt == RCIT_HM |-> min_ok(r.setp) && min_ok(r.dly))
    else $error("hours-minutes format with odd seconds");
  a_code_defer: assert property (@(posedge ref_clk) disable iff (reset)
    r.cfg_mode && next_r.cfg_mode |=> $stable(r.code_act))
    else $error("access code changed inside configuration");
  a_cycle_bound: assert property (@(posedge ref_clk) disable iff (reset)
    r.cfg.cyc_en && r.rcnt != 7'h00 && r.st == RCIT_RUN |-> r.done_cyc < r.rcnt)
    else $error("ran more cycles than requested");
  a_idle_restore: assert property (@(posedge ref_clk) disable iff (reset)
    pwr_evt && r.st != RCIT_IDLE && r.cfg.policy == RCIT_P_IDLE |=>
    r.st == RCIT_DONE && $stable(r.el))
    else $error("idle policy did not hold completed state");
  a_pause_restore: assert property (@(posedge ref_clk) disable iff (reset)
    pwr_evt && r.st != RCIT_IDLE && r.cfg.policy == RCIT_P_PAUSE |=>
    r.st == ($past(start_lvl) ? RCIT_RUN : RCIT_PAUSE))
    else $error("pause policy wrong state");
  a_cont_restore: assert property (@(posedge ref_clk) disable iff (reset)
    pwr_evt && r.cfg.policy[1] && r.st != RCIT_IDLE |=>
    r.st == $past(r.st) && $stable(r.el))
    else $error("continue policy changed state");
  a_tick_rate: assert property (@(posedge ref_clk) disable iff (reset)
    tick && r.st == RCIT_RUN && !stop_evt && !pwr_evt && !rst_evt &&
    !(wr && apb_req.paddr == `RCIT_OFF_CMD && apb_req.pwdata[0]) &&
    r.el + 19'h00001 < r.setp |=> r.el == $past(r.el) + 19'h00001)
    else $error("count did not advance on second tick");
  a_repeat_keep: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(r.cfg.cyc_en) |-> $stable(r.rcnt) && $stable(r.dly))
    else $error("repeat enable disturbed its settings");
  c_repeat_delay: cover property (@(posedge ref_clk) disable iff (reset)
    r.st == RCIT_RUN ##1 r.st == RCIT_DELAY);
  c_done: cover property (@(posedge ref_clk) disable iff (reset) r.st == RCIT_DONE);
  c_pause_resume: cover property (@(posedge ref_clk) disable iff (reset)
    r.st == RCIT_PAUSE ##1 r.st == RCIT_RUN);
  c_power_return: cover property (@(posedge ref_clk) disable iff (reset)
    pwr_evt && r.st == RCIT_RUN);
endmodule

//--- logic/rcit_cfg.svh
// Purpose: Constants of the repeat cycle interval timer: offsets, resets, limits, timing.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Types live in rcit_pkg; this header holds numbers only.
`ifndef RCIT_CFG_SVH
`define RCIT_CFG_SVH
`define RCIT_OFF_CTRL 8'h00
`define RCIT_OFF_SETP 8'h04
`define RCIT_OFF_RCNT 8'h08
`define RCIT_OFF_DLY 8'h0c
`define RCIT_OFF_CODE 8'h10
`define RCIT_OFF_CFGM 8'h14
`define RCIT_OFF_UNLK 8'h18
`define RCIT_OFF_CMD 8'h1c
`define RCIT_OFF_STAT 8'h20
`define RCIT_OFF_TIME 8'h24
`define RCIT_OFF_TOT 8'h28
`define RCIT_OFF_DREM 8'h2c
`define RCIT_CTRL_RST 11'h000
`define RCIT_MAX_SEC 19'h57e3f
`define RCIT_MAX_HM_SEC 19'h57e04
`define RCIT_MAX_CYC 7'h63
`define RCIT_SEC_PER_TENTH 9'h168
`define RCIT_TICK_NS 1000000000
`define RCIT_CLK_NS 50
`define RCIT_SEC_CYCLES (`RCIT_TICK_NS / `RCIT_CLK_NS)
`endif

//--- logic/rcit_pkg.sv
// Purpose: Types of the repeat cycle interval timer.
// Assumes: rcit_cfg.svh gives the numbers.
// Notes: All module state is the packed rcit_regs_t.
package rcit_pkg;
  typedef enum logic [2:0] {
    RCIT_IDLE = 3'b000, RCIT_RUN = 3'b001, RCIT_PAUSE = 3'b010,
    RCIT_DELAY = 3'b011, RCIT_DONE = 3'b100
  } rcit_state_t;
  typedef enum logic [1:0] {
    RCIT_HMS = 2'b00, RCIT_HM = 2'b01, RCIT_MS = 2'b10, RCIT_S = 2'b11
  } rcit_fmt_t;
  typedef enum logic [1:0] {
    RCIT_P_IDLE = 2'b00, RCIT_P_PAUSE = 2'b01, RCIT_P_CONT = 2'b10, RCIT_P_RSV = 2'b11
  } rcit_policy_t;
  typedef struct packed {
    logic trst_en;
    logic lrst_en;
    logic adj_en;
    rcit_policy_t policy;
    logic cyc_en;
    rcit_fmt_t fmt;
    logic prox;
    logic ctl2;
    logic dir_up;
  } rcit_cfg_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rcit_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rcit_apb_rsp_t;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    rcit_state_t st;
    logic [31:0] pre;
    logic [18:0] el;
    logic [18:0] dl;
    logic [18:0] setp;
    logic [18:0] dly;
    logic [6:0] rcnt;
    logic [6:0] done_cyc;
    rcit_cfg_t cfg;
    logic cfg_mode;
    logic unlocked;
    logic [15:0] code_pend;
    logic [15:0] code_act;
    logic [8:0] run_sec;
    logic [15:0] tenths;
    logic [31:0] prdata;
  } rcit_regs_t;
endpackage

//--- tb/rcit_panel.sv
// Purpose: Panel buttons, sensor level and supply-return event.
// Assumes: Clean levels; no bounce is modelled.
// Notes: Pulses are held 4 edges so the 3-edge pin sync sees them.
`timescale 1ns/10ps
module rcit_panel (
  // Clock
  input wire logic ref_clk,
  // Pins toward the timer
  output logic sensor_in,
  output logic start_btn,
  output logic stop_btn,
  output logic reset_btn,
  output logic total_btn,
  output logic power_return
);
  logic [4:0] btn = 5'h00;
  // Buttons and supply event share one vector
  assign {power_return, total_btn, reset_btn, stop_btn, start_btn} = btn;
  initial sensor_in = 1'b0;
  // Short press, then a gap before the next one
  task automatic press(input int idx);
    @(posedge ref_clk) btn[idx] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    btn[idx] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Sensor moves just after an edge
  task automatic sense(input logic lvl);
    @(posedge ref_clk) sensor_in <= lvl;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

//--- tb/repeat_cycle_interval_timer_test.sv
// Purpose: Self-checking bench of the repeat cycle interval timer.
// Assumes: SEC_CYCLES cut to 10, so one second is 10 clocks.
// Notes: Xorshift stimulus from a fixed seed; expectations from bench functions.
`timescale 1ns/10ps
`include "rcit_cfg.svh"
module repeat_cycle_interval_timer_test;
  import rcit_pkg::*;
  localparam int SC = 10;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  rcit_apb_req_t apb_req = '0;
  rcit_apb_rsp_t apb_rsp;
  rcit_state_t timer_state;
  logic [18:0] shown_sec;
  logic sensor_in, start_btn, stop_btn, reset_btn, total_btn, power_return;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000d907;
  logic [31:0] rd_d;
  logic rd_e;
  rcit_cfg_t c;
  rcit_timer #(.SEC_CYCLES(SC)) rcit_timer_inst (
    .ref_clk(ref_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sensor_in(sensor_in), .start_btn(start_btn), .stop_btn(stop_btn),
    .reset_btn(reset_btn), .total_btn(total_btn), .power_return(power_return),
    .timer_state(timer_state), .shown_sec(shown_sec));
  rcit_panel rcit_panel_inst (
    .ref_clk(ref_clk), .sensor_in(sensor_in), .start_btn(start_btn),
    .stop_btn(stop_btn), .reset_btn(reset_btn), .total_btn(total_btn),
    .power_return(power_return));
  // 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Time as the registers present it in each format
  function automatic logic [31:0] fmtv(input logic [18:0] s, input rcit_fmt_t f);
    case (f)
      RCIT_HMS: return {8'h00, 8'(s / 3600), 8'(s / 60 % 60), 8'(s % 60)};
      RCIT_HM: return {16'h0000, 8'(s / 3600), 8'(s / 60 % 60)};
      RCIT_MS: return {8'h00, 16'(s / 60), 8'(s % 60)};
      default: return {13'h0000, s};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; an idle edge after release keeps drives apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    // Access ends on the first edge that sees pready high
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd_d = apb_rsp.prdata;
    rd_e = apb_rsp.pslverr;
    if (wr) chk("wr_pslverr", 32'h0, {31'h0, rd_e});
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd_d);
  endtask
  task automatic ctl(input rcit_cfg_t k);
    wr(`RCIT_OFF_CFGM, 32'h1);
    wr(`RCIT_OFF_CTRL, {21'h000000, k});
    wr(`RCIT_OFF_CFGM, 32'h0);
  endtask
  // Idle the timer, load setpoint, then control word
  task automatic setup(input rcit_cfg_t k, input logic [18:0] sp);
    wr(`RCIT_OFF_CMD, 32'h1);
    wr(`RCIT_OFF_CFGM, 32'h1);
    wr(`RCIT_OFF_SETP, {13'h0000, sp});
    wr(`RCIT_OFF_CFGM, 32'h0);
    ctl(k);
  endtask
  task automatic wait_st(input rcit_state_t s, input int lim);
    int n;
    n = 0;
    while (timer_state !== s && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("timer_state", 32'(s), 32'(timer_state));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the few thousand clocks the tests need
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    int sp;
    int i;
    rcit_state_t pw [3];
    pw = '{RCIT_DONE, RCIT_PAUSE, RCIT_RUN};
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdchk("ctrl", `RCIT_OFF_CTRL, 32'h0);
    rdchk("hole", 8'h30, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rd_e});
    c = '0;
    setup(c, 19'h0);
    rcit_panel_inst.press(0);
    chk("zero_start", 32'(RCIT_IDLE), 32'(timer_state));
    $display("test reset and zero setpoint done");
    for (i = 0; i < 4; i++) begin
      c.fmt = rcit_fmt_t'(i);
      setup(c, 19'd120);
      rdchk("setp", `RCIT_OFF_SETP, fmtv(19'd120, c.fmt));
      rdchk("time", `RCIT_OFF_TIME, fmtv(19'd120, c.fmt));
    end
    c.fmt = RCIT_HM;
    setup(c, 19'd61);
    // Refused hours-minutes keeps the plain seconds format
    rdchk("fmt_hm", `RCIT_OFF_CTRL, 32'h00000018);
    c.fmt = RCIT_S;
    ctl(c);
    wr(`RCIT_OFF_CFGM, 32'h1);
    wr(`RCIT_OFF_DLY, 32'h00061a80);
    wr(`RCIT_OFF_RCNT, 32'h5);
    wr(`RCIT_OFF_RCNT, 32'h64);
    wr(`RCIT_OFF_CFGM, 32'h0);
    rdchk("dly_max", `RCIT_OFF_DLY, fmtv(19'd359999, RCIT_S));
    rdchk("rcnt", `RCIT_OFF_RCNT, 32'h5);
    c.fmt = RCIT_HMS;
    ctl(c);
    rdchk("dly_hms", `RCIT_OFF_DLY, fmtv(19'd359999, RCIT_HMS));
    $display("test formats done");
    for (i = 0; i < 2; i++) begin
      sp = 1 + xs() % 4;
      c = '0;
      c.dir_up = i[0];
      setup(c, 19'(sp));
      rcit_panel_inst.press(0);
      wait_st(RCIT_RUN, 8);
      wait_st(RCIT_DONE, sp * SC + 20);
      chk("shown", i ? sp : 0, {13'h0000, shown_sec});
      rcit_panel_inst.press(2);
      chk("rst_off", 32'(RCIT_DONE), 32'(timer_state));
      c.lrst_en = 1'b1;
      ctl(c);
      rcit_panel_inst.press(2);
      wait_st(RCIT_IDLE, 4);
    end
    $display("test count directions done");
    c = '0;
    c.cyc_en = 1'b1;
    setup(c, 19'd2);
    wr(`RCIT_OFF_CFGM, 32'h1);
    wr(`RCIT_OFF_RCNT, 32'h2);
    wr(`RCIT_OFF_DLY, 32'h1);
    wr(`RCIT_OFF_CFGM, 32'h0);
    rcit_panel_inst.press(0);
    wait_st(RCIT_DELAY, 3 * SC + 20);
    wait_st(RCIT_RUN, 2 * SC + 10);
    wait_st(RCIT_DONE, 3 * SC + 20);
    rdchk("cycles", `RCIT_OFF_STAT, 32'h00000024);
    c.cyc_en = 1'b0;
    ctl(c);
    rdchk("rcnt_kept", `RCIT_OFF_RCNT, 32'h2);
    rdchk("dly_kept", `RCIT_OFF_DLY, fmtv(19'd1, RCIT_HMS));
    $display("test repeat done");
    for (i = 0; i < 4; i++) begin
      c = '0;
      c.ctl2 = i[0];
      c.prox = i[1];
      rcit_panel_inst.sense(c.ctl2 ^ c.prox);
      setup(c, 19'd100);
      rcit_panel_inst.sense(~(c.ctl2 ^ c.prox));
      wait_st(RCIT_RUN, 8);
      rcit_panel_inst.sense(c.ctl2 ^ c.prox);
      wait_st(RCIT_PAUSE, 8);
    end
    $display("test sensor control done");
    for (i = 0; i < 3; i++) begin
      c = '0;
      c.policy = rcit_policy_t'(i);
      c.lrst_en = 1'b1;
      setup(c, 19'd100);
      rcit_panel_inst.press(0);
      wait_st(RCIT_RUN, 8);
      rcit_panel_inst.press(4);
      wait_st(pw[i], 8);
      rcit_panel_inst.press(i == 0 ? 2 : 0);
      wait_st(i == 0 ? RCIT_IDLE : RCIT_RUN, 8);
      if (i == 0) rdchk("cyc_clr", `RCIT_OFF_STAT, 32'h0);
    end
    $display("test power return done");
    c = '0;
    setup(c, 19'h00190);
    wr(`RCIT_OFF_CMD, 32'h2);
    rcit_panel_inst.press(0);
    wait_st(RCIT_RUN, 8);
    // Stop lands midway between the 365th and 366th second
    repeat (365 * SC - 4) @(posedge ref_clk);
    rcit_panel_inst.press(1);
    wait_st(RCIT_PAUSE, 8);
    chk("paused", 32'h00000023, {13'h0000, shown_sec});
    rdchk("time_hms", `RCIT_OFF_TIME, fmtv(19'h00023, RCIT_HMS));
    rdchk("total", `RCIT_OFF_TOT, 32'h1);
    rdchk("dly_rem", `RCIT_OFF_DREM, fmtv(19'h00001, RCIT_HMS));
    rcit_panel_inst.press(3);
    rdchk("tot_off", `RCIT_OFF_TOT, 32'h1);
    c.trst_en = 1'b1;
    ctl(c);
    rcit_panel_inst.press(3);
    rdchk("tot_clr", `RCIT_OFF_TOT, 32'h0);
    $display("test stop and run total done");
    c = '0;
    c.adj_en = 1'b1;
    setup(c, 19'd5);
    wr(`RCIT_OFF_SETP, 32'h6);
    rdchk("open_code", `RCIT_OFF_SETP, fmtv(19'd6, RCIT_HMS));
    wr(`RCIT_OFF_CFGM, 32'h1);
    wr(`RCIT_OFF_CODE, 32'h1234);
    wr(`RCIT_OFF_CFGM, 32'h0);
    wr(`RCIT_OFF_SETP, 32'h7);
    rdchk("locked", `RCIT_OFF_SETP, fmtv(19'd6, RCIT_HMS));
    wr(`RCIT_OFF_UNLK, 32'h1234);
    wr(`RCIT_OFF_SETP, 32'h7);
    rdchk("unlocked", `RCIT_OFF_SETP, fmtv(19'd7, RCIT_HMS));
    $display("test access code done");
    wrap_up();
  end
endmodule
